// ===== pkg/low_power_defines.vh
// Constants for the low-power mode and wake-up controller.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register port.
`ifndef LOW_POWER_DEFINES_VH
`define LOW_POWER_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LP_ADR_FAST_STARTUP 8'h00
`define LP_ADR_BACKUP_WAKE 8'h04
`define LP_ADR_DEBOUNCE 8'h08
`define LP_ADR_CLOCK_CTRL 8'h0c
`define LP_ADR_STATUS 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LP_FS_CAL_BIT 16
`define LP_FS_TIMER_BIT 17
`define LP_FS_USB_BIT 18
`define LP_FS_LPSEL_BIT 20
`define LP_BW_FORCE_BIT 16
`define LP_BW_BROWN_BIT 17
`define LP_BW_CAL_BIT 18
`define LP_BW_TIMER_BIT 19
`define LP_CC_RC_BIT 0
`define LP_CC_SLOWXTAL_BIT 3
`define LP_CC_PERIPH_BIT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LP_RST_FAST_STARTUP 32'h0000_0000
`define LP_RST_BACKUP_WAKE 32'h0000_0000
`define LP_RST_DEBOUNCE 32'h0000_0000
`define LP_RST_CLOCK_CTRL 5'h11

// ----------------------------------------
// Main clock sources
// ----------------------------------------
`define LP_MCK_FAST_RC 2'h0
`define LP_MCK_CRYSTAL 2'h1
`define LP_MCK_PLL 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define LP_CLOCK_MHZ 40
`define LP_BACKUP_RECOVER_US 400
`define LP_BACKUP_RECOVER_CYCLES (`LP_BACKUP_RECOVER_US * `LP_CLOCK_MHZ)
`define LP_RC_RESTART_NS 5000
`define LP_RC_RESTART_CYCLES ((`LP_RC_RESTART_NS * `LP_CLOCK_MHZ + 999) / 1000)

`endif

// ===== design/low_power_mode_wakeup_control.v
// Low-power mode controller: sleep, wait and backup entry, wake-up and restart.
// Assumes the core gives one-cycle pulses for its wait instructions and that
// every pin input is already synchronous to the clock.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "low_power_defines.vh"

module low_power_mode_wakeup_control #(
  parameter DEB_W = 16,
  parameter TIMER_W = 16,
  parameter [TIMER_W-1:0] BACKUP_RECOVER_CYCLES = `LP_BACKUP_RECOVER_CYCLES,
  parameter [TIMER_W-1:0] RC_RESTART_CYCLES = `LP_RC_RESTART_CYCLES
) (
  // Clock and reset.
  input wire clock,
  input wire sys_rst,
  // Wishbone register port.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Processor core.
  input wire waitEventExec,
  input wire waitIntExec,
  input wire deepSleepSelect,
  input wire coreInterrupt,
  input wire coreEvent,
  // Wake-up sources.
  input wire forceWakeupN,
  input wire [15:0] wakeupInputs,
  input wire brownoutAlarm,
  input wire calendarAlarm,
  input wire timerAlarm,
  input wire usbWakeup,
  // Power and clock controls.
  output reg regulatorShutdownN,
  output reg coreResetN,
  output reg coreClockEnable,
  output reg periphClockEnable,
  output reg memClockEnable,
  output reg [1:0] mainClockSelect,
  output reg slowCrystalSelect,
  output wire fastRcEnable,
  output wire fastStartupRequest,
  output reg [2:0] powerMode
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ACTIVE = 3'h0;
  localparam SLEEP = 3'h1;
  localparam WAITING = 3'h2;
  localparam BACKUP = 3'h3;
  localparam POWERUP = 3'h4;
  localparam RESTART = 3'h5;

  // Byte-lane merge used by every writable register except clockCtrl, which is written only when lane 0 is selected.
  function [31:0] laneMerge;
    input [31:0] oldValue;
    input [31:0] newValue;
    input [3:0] sel;
    integer i;
    begin
      laneMerge = oldValue;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (sel[i])
        begin
          laneMerge[i*8 +: 8] = newValue[i*8 +: 8];
        end
      end
    end
  endfunction

  // Modes in which memories and peripherals keep their clocks; one test
  // gates both enables, and the peripheral enable is also gated by clockCtrl bit 4.
  function busClocked;
    input [2:0] mode;
    begin
      busClocked = (mode == ACTIVE) || (mode == SLEEP);
    end
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [31:0] fastStartupModeReg;
  reg [31:0] backupWakeEnable;
  reg [31:0] debounceReg;
  reg [4:0] clockCtrl;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [TIMER_W-1:0] timer;
  reg [DEB_W-1:0] forceCount;
  reg [DEB_W-1:0] inputCount;
  reg [15:0] entrySnapshot;
  reg sleptOnInterrupt;
  reg [4:0] wakeCause;

  // A write lands once, at the edge that raises ack; the held request is then ignored.
  wire busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire lowPowerSelect = fastStartupModeReg[`LP_FS_LPSEL_BIT];

  // Mode changes that load the timer and hand the main clock back to the RC.
  wire enterRestart = (state == WAITING) && (next_state == RESTART);
  wire enterPowerup = (state == BACKUP) && (next_state == POWERUP);
  wire timerDone = (timer == {TIMER_W{1'b0}});

  // Fast start is plain gating of pins, so it needs no running clock.
  // It is held off outside wait, so a low pin in active mode does nothing.
  assign fastStartupRequest = (state == WAITING) &
    ((|(~wakeupInputs & fastStartupModeReg[15:0])) |
     (calendarAlarm & fastStartupModeReg[`LP_FS_CAL_BIT]) |
     (timerAlarm & fastStartupModeReg[`LP_FS_TIMER_BIT]) |
     (usbWakeup & fastStartupModeReg[`LP_FS_USB_BIT]));

  // ----------------------------------------
  // Backup wake-up detection
  // ----------------------------------------
  // A source must hold for the programmed count plus one cycle.
  // Alarms bypass the count: they come from clocked logic and cannot bounce.
  wire forceActive = ~forceWakeupN & backupWakeEnable[`LP_BW_FORCE_BIT];
  wire inputActive = |((wakeupInputs ^ entrySnapshot) & backupWakeEnable[15:0]);
  wire forceEvent = forceActive & (forceCount == debounceReg[DEB_W-1:0]);
  wire inputEvent = inputActive & (inputCount == debounceReg[16 +: DEB_W]);
  wire alarmEvent = (brownoutAlarm & backupWakeEnable[`LP_BW_BROWN_BIT]) |
    (calendarAlarm & backupWakeEnable[`LP_BW_CAL_BIT]) |
    (timerAlarm & backupWakeEnable[`LP_BW_TIMER_BIT]);
  wire backupWake = (state == BACKUP) & (forceEvent | inputEvent | alarmEvent);

  // Debounce counters run only in backup and saturate at the threshold.
  // Any break in the level restarts the count, so a pin glitch shorter
  // than the programmed length can never power the core back up.
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      forceCount <= {DEB_W{1'b0}};
      inputCount <= {DEB_W{1'b0}};
    end
    else
    begin
      if (state != BACKUP || !forceActive)
        forceCount <= {DEB_W{1'b0}};
      else if (!forceEvent)
        forceCount <= forceCount + 1'b1;
      if (state != BACKUP || !inputActive)
        inputCount <= {DEB_W{1'b0}};
      else if (!inputEvent)
        inputCount <= inputCount + 1'b1;
    end
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  // Wait instructions are only honoured from active mode.
  // A wait-for-interrupt with either select bit set is ignored: the
  // core simply runs on rather than entering a mode it cannot leave.
  always @*
  begin
    next_state = state;
    case (state)
      ACTIVE:
      begin
        if (waitEventExec && deepSleepSelect)
          next_state = BACKUP;
        else if (waitEventExec && lowPowerSelect)
          next_state = WAITING;
        else if ((waitEventExec || waitIntExec) && !lowPowerSelect && !deepSleepSelect)
          next_state = SLEEP;
      end
      SLEEP:
      begin
        if (sleptOnInterrupt ? coreInterrupt : coreEvent)
          next_state = ACTIVE;
      end
      WAITING:
      begin
        if (fastStartupRequest)
          next_state = RESTART;
      end
      BACKUP:
      begin
        if (backupWake)
          next_state = POWERUP;
      end
      POWERUP:
      begin
        if (timerDone)
          next_state = ACTIVE;
      end
      RESTART:
      begin
        if (timerDone)
          next_state = ACTIVE;
      end
      default:
        next_state = ACTIVE;
    endcase
  end

  // State, timer and entry bookkeeping.
  // The timer stops at zero, so a stale count never cuts a later power-up short.
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ACTIVE;
      timer <= {TIMER_W{1'b0}};
      entrySnapshot <= 16'h0000;
      sleptOnInterrupt <= 1'b0;
      wakeCause <= 5'h00;
    end
    else
    begin
      state <= next_state;
      if (enterPowerup)
        timer <= BACKUP_RECOVER_CYCLES - 1'b1;
      else if (enterRestart)
        timer <= RC_RESTART_CYCLES - 1'b1;
      else if (!timerDone)
        timer <= timer - 1'b1;
      if (state == ACTIVE && next_state == BACKUP)
        entrySnapshot <= wakeupInputs;
      if (state == ACTIVE && next_state == SLEEP)
        sleptOnInterrupt <= waitIntExec & ~waitEventExec;
      if (backupWake)
        wakeCause <= {timerAlarm & backupWakeEnable[`LP_BW_TIMER_BIT],
                      calendarAlarm & backupWakeEnable[`LP_BW_CAL_BIT],
                      brownoutAlarm & backupWakeEnable[`LP_BW_BROWN_BIT],
                      inputEvent, forceEvent};
    end
  end

  // ----------------------------------------
  // Power and clock outputs
  // ----------------------------------------
  // Outputs are decoded from the next state so they change with the state flop.
  // Decoding the current state would leave clocks running one cycle into a mode.
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      regulatorShutdownN <= 1'b1;
      coreResetN <= 1'b1;
      coreClockEnable <= 1'b1;
      periphClockEnable <= 1'b1;
      memClockEnable <= 1'b1;
      powerMode <= ACTIVE;
    end
    else
    begin
      powerMode <= next_state;
      regulatorShutdownN <= (next_state != BACKUP);
      coreResetN <= (next_state != BACKUP) && (next_state != POWERUP);
      coreClockEnable <= (next_state == ACTIVE);
      memClockEnable <= busClocked(next_state);
      periphClockEnable <= busClocked(next_state) && clockCtrl[`LP_CC_PERIPH_BIT];
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // The slow oscillator choice lives here so it survives every mode.
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fastStartupModeReg <= `LP_RST_FAST_STARTUP;
      backupWakeEnable <= `LP_RST_BACKUP_WAKE;
      debounceReg <= `LP_RST_DEBOUNCE;
      clockCtrl <= `LP_RST_CLOCK_CTRL;
    end
    else
    begin
      if (busWrite && wb_adr_i == `LP_ADR_FAST_STARTUP)
        fastStartupModeReg <= laneMerge(fastStartupModeReg, wb_dat_i, wb_sel_i) &
          32'h0017_ffff;
      if (busWrite && wb_adr_i == `LP_ADR_BACKUP_WAKE)
        backupWakeEnable <= laneMerge(backupWakeEnable, wb_dat_i, wb_sel_i) &
          32'h000f_ffff;
      if (busWrite && wb_adr_i == `LP_ADR_DEBOUNCE)
        debounceReg <= laneMerge(debounceReg, wb_dat_i, wb_sel_i);
      if (busWrite && wb_adr_i == `LP_ADR_CLOCK_CTRL && wb_sel_i[0])
        clockCtrl <= wb_dat_i[4:0];
      // Hardware wins over a software write in the same cycle.
      // Software polling the RC enable therefore sees the clear it waits for.
      if (state == ACTIVE && next_state == WAITING)
        clockCtrl[`LP_CC_RC_BIT] <= 1'b0;
      if (enterRestart || enterPowerup)
      begin
        clockCtrl[`LP_CC_RC_BIT] <= 1'b1;
        clockCtrl[2:1] <= `LP_MCK_FAST_RC;
      end
    end
  end

  assign fastRcEnable = clockCtrl[`LP_CC_RC_BIT];

  // Clock source outputs follow the control register one cycle later.
  // Registering them keeps the bus write path away from the clock multiplexers.
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mainClockSelect <= `LP_MCK_FAST_RC;
      slowCrystalSelect <= 1'b0;
    end
    else
    begin
      mainClockSelect <= clockCtrl[2:1];
      slowCrystalSelect <= clockCtrl[`LP_CC_SLOWXTAL_BIT];
    end
  end

  // ----------------------------------------
  // Wishbone answer
  // ----------------------------------------
  // One wait state; unmapped offsets answer with zero so software never hangs.
  // Read data is loaded every cycle, so it is settled in the ack cycle.
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        `LP_ADR_FAST_STARTUP: wb_dat_o <= fastStartupModeReg;
        `LP_ADR_BACKUP_WAKE: wb_dat_o <= backupWakeEnable;
        `LP_ADR_DEBOUNCE: wb_dat_o <= debounceReg;
        `LP_ADR_CLOCK_CTRL: wb_dat_o <= {27'h0000000, clockCtrl};
        `LP_ADR_STATUS: wb_dat_o <= {19'h00000, wakeCause, 5'h00, state};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule // low_power_mode_wakeup_control

`default_nettype wire

// ===== tb/lp_checker_props.sv
// Checker for the low-power controller, bound to its top module.
// Assumes one clock domain and the powerMode encoding of the design.
`timescale 1ns/1ps
`default_nettype none
module lp_checker_props (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Core side.
  input wire logic waitEventExec,
  input wire logic deepSleepSelect,
  input wire logic coreInterrupt,
  input wire logic coreEvent,
  // Power and clock controls.
  input wire logic regulatorShutdownN,
  input wire logic coreResetN,
  input wire logic coreClockEnable,
  input wire logic memClockEnable,
  input wire logic [1:0] mainClockSelect,
  input wire logic fastRcEnable,
  input wire logic fastStartupRequest,
  input wire logic [2:0] powerMode
);
  logic [15:0] upCount;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // Power-up length; counted because it is far beyond any delay range.
  always @(posedge clock or posedge sys_rst)
    if (sys_rst || powerMode != 3'h4)
      upCount <= 16'h0000;
    else
      upCount <= upCount + 16'h0001;
  property p_bkIn;
    powerMode == 3'h0 && waitEventExec && deepSleepSelect |=> powerMode == 3'h3 && !regulatorShutdownN;
  endproperty
  a_bkIn: assert property (p_bkIn) else $error("no backup entry");
  property p_waitClk;
    powerMode == 3'h2 |-> !coreClockEnable && !memClockEnable;
  endproperty
  a_waitClk: assert property (p_waitClk) else $error("clock runs in wait");
  property p_sleepClk;
    powerMode == 3'h1 |-> !coreClockEnable && memClockEnable;
  endproperty
  a_sleepClk: assert property (p_sleepClk) else $error("bad sleep clocks");
  property p_sleepWake;
    powerMode == 3'h1 && coreInterrupt && coreEvent |=> powerMode == 3'h0;
  endproperty
  a_sleepWake: assert property (p_sleepWake) else $error("sleep kept");
  property p_fast;
    powerMode == 3'h2 && fastStartupRequest |=> fastRcEnable && mainClockSelect == 2'h0;
  endproperty
  a_fast: assert property (p_fast) else $error("no fast restart");
  property p_waitWake;
    $rose(fastStartupRequest) |-> ##[1:400] powerMode == 3'h0 && coreClockEnable;
  endproperty
  a_waitWake: assert property (p_waitWake) else $error("slow wait wake");
  property p_powerUp;
    powerMode == 3'h4 |-> !coreResetN && regulatorShutdownN;
  endproperty
  a_powerUp: assert property (p_powerUp) else $error("bad power-up");
  property p_recover;
    upCount < 16'd20000;
  endproperty
  a_recover: assert property (p_recover) else $error("slow recovery");
endmodule // lp_checker_props
bind low_power_mode_wakeup_control lp_checker_props checker0 (.clock(clock), .sys_rst(sys_rst),
  .waitEventExec(waitEventExec), .deepSleepSelect(deepSleepSelect),
  .coreInterrupt(coreInterrupt), .coreEvent(coreEvent), .coreResetN(coreResetN),
  .regulatorShutdownN(regulatorShutdownN), .coreClockEnable(coreClockEnable),
  .memClockEnable(memClockEnable), .mainClockSelect(mainClockSelect),
  .fastRcEnable(fastRcEnable), .fastStartupRequest(fastStartupRequest), .powerMode(powerMode));
`default_nettype wire

// ===== tb/core_model.sv
// Processor core model: wait instructions and sleep wake-up lines.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock.
  input wire logic clock,
  // Instructions and wake lines.
  output logic waitEventExec = 1'b0,
  output logic waitIntExec = 1'b0,
  output logic deepSleepSelect = 1'b0,
  output logic coreInterrupt = 1'b0,
  output logic coreEvent = 1'b0
);
  // One-cycle instruction pulse; the deep-sleep bit stays as a level.
  task issue(input logic evt, input logic deep);
  begin
    waitEventExec <= evt;
    waitIntExec <= !evt;
    deepSleepSelect <= deep;
    @(posedge clock);
    waitEventExec <= 1'b0;
    waitIntExec <= 1'b0;
  end
  endtask
  // Interrupt and event levels seen by a sleeping core.
  task wake(input logic irq, input logic evt);
  begin
    coreInterrupt <= irq;
    coreEvent <= evt;
  end
  endtask
endmodule // core_model
`default_nettype wire

// ===== tb/test_low_power_mode_wakeup_control.sv
// Self-checking bench for the low-power controller.
// Assumes the checker and core model files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_low_power_mode_wakeup_control;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic forceWakeupN = 1'b1;
  logic [15:0] wakeupInputs = 16'hffff;
  logic [3:0] srcs = 4'h0;
  logic [7:0] seed = 8'h3c;
  wire [31:0] datO;
  wire ack, wait_event_instruction, wait_interrupt_instruction, deep, irq, evt, rsN, crN, cClk, pClk, mClk, slowX, rcEn, fsReq;
  wire [1:0] mck;
  wire [2:0] powerMode;
  int mismatches = 0;
  int samples_checked = 0;
  int n, i, k;
  // The clock inverts every half period of 12.5 ns, a period of 25 ns.
  always #12.5 clock = !clock;
  core_model core (.clock(clock), .waitEventExec(wait_event_instruction), .waitIntExec(wait_interrupt_instruction),
    .deepSleepSelect(deep), .coreInterrupt(irq), .coreEvent(evt));
  low_power_mode_wakeup_control #(.BACKUP_RECOVER_CYCLES(16'd20), .RC_RESTART_CYCLES(16'd5)) DUT (
    .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack),
    .waitEventExec(wait_event_instruction), .waitIntExec(wait_interrupt_instruction), .deepSleepSelect(deep), .coreInterrupt(irq),
    .coreEvent(evt), .forceWakeupN(forceWakeupN), .wakeupInputs(wakeupInputs),
    .brownoutAlarm(srcs[0]), .calendarAlarm(srcs[1]), .timerAlarm(srcs[2]), .usbWakeup(srcs[3]),
    .regulatorShutdownN(rsN), .coreResetN(crN), .coreClockEnable(cClk),
    .periphClockEnable(pClk), .memClockEnable(mClk), .mainClockSelect(mck),
    .slowCrystalSelect(slowX), .fastRcEnable(rcEn), .fastStartupRequest(fsReq),
    .powerMode(powerMode));
  // Random source of pin numbers.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task end_sim(input logic hung);
  begin
    if (hung)
      mismatches++;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // Classic single cycle; held until ack is sampled, then one idle cycle.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      end_sim(1'b1);
    rdat = datO;
    cyc <= 1'b0;
    @(posedge clock);
  end
  endtask
  task waitMode(input logic [2:0] m);
  begin
    n = 0;
    while (powerMode !== m && n < 30000)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 30000)
      end_sim(1'b1);
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    wb(0, 8'h0c, 0);
    chk("clockCtrl", rdat, 32'h11);
    wb(0, 8'h20, 0);
    chk("unmapped", rdat, 0);
    for (i = 0; i < 3; i++)
    begin
      wb(1, 8'h0c, 32'h11 | (i << 1) | (i[0] << 3));
      chk("mainClock", mck, i);
      chk("slowXtal", slowX, i[0]);
    end
    $display("clock select done");
    for (i = 0; i < 2; i++)
    begin
      core.issue(i[0], 0);
      @(posedge clock);
      chk("sleepMode", powerMode, 1);
      chk("coreSleep", cClk, 0);
      chk("periphSleep", pClk, 1);
      core.wake(i[0], !i[0]);
      repeat (2) @(posedge clock);
      chk("wrongWake", powerMode, 1);
      core.wake(1, 1);
      repeat (2) @(posedge clock);
      chk("sleepExit", powerMode, 0);
      core.wake(0, 0);
    end
    $display("sleep done");
    for (i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      k = seed[3:0];
      wb(1, 8'h0c, 32'h11);
      wb(1, 8'h00, (i == 0 ? 32'h1 << k : 32'h1 << (15 + i)) | 32'h10_0000);
      core.issue(1, 0);
      @(posedge clock);
      chk("waitMode", powerMode, 2);
      chk("periphWait", pClk, 0);
      wb(0, 8'h0c, 0);
      chk("rcPoll", rdat[0], 0);
      chk("quietReq", fsReq, 0);
      if (i == 0)
        wakeupInputs[k] <= 1'b0;
      else
        srcs[i] <= 1'b1;
      #1;
      chk("fastReq", fsReq, 1);
      waitMode(0);
      chk("wakeFast", n <= 400, 1);
      chk("rcBack", {rcEn, mck}, 3'h4);
      wakeupInputs <= 16'hffff;
      srcs <= 4'h0;
    end
    core.issue(0, 0);
    @(posedge clock);
    chk("wfiLowPower", powerMode, 0);
    $display("wait done");
    k = seed[7:4];
    wb(1, 8'h08, 32'h0002_0003);
    wb(1, 8'h04, 32'h000f_0000 | (32'h1 << k));
    for (i = 0; i < 5; i++)
    begin
      wb(1, 8'h0c, 32'h14);
      core.issue(1, 1);
      @(posedge clock);
      chk("backup", {powerMode, rsN}, 4'h6);
      if (i == 0)
        forceWakeupN <= 1'b0;
      else if (i == 1)
        wakeupInputs[k] <= !wakeupInputs[k];
      else
        srcs[i - 2] <= 1'b1;
      waitMode(0);
      chk("recovery", n < 20000, 1);
      chk("rcAfterBackup", {rcEn, mck}, 3'h4);
      forceWakeupN <= 1'b1;
      srcs <= 4'h0;
      wb(0, 8'h10, 0);
      chk("wakeCause", rdat[12:8], 1 << i);
    end
    wb(1, 8'h0c, 32'h01);
    chk("periphOff", pClk, 0);
    $display("backup done");
    end_sim(1'b0);
  end
endmodule // test_low_power_mode_wakeup_control
`default_nettype wire
